// File: inc/asu_cfg.svh
// Offsets, field positions, reset values and sizes of the accumulator/stack store unit
`ifndef ASU_CFG_SVH
`define ASU_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define ASU_ADR_CTRL 8'h00
`define ASU_ADR_STAT 8'h04
`define ASU_ADR_ACC 8'h08
`define ASU_ADR_TOS 8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASU_CTRL_EN_BIT 0
`define ASU_ST_SIGN_BIT 0
`define ASU_ST_LZERO_BIT 1
`define ASU_ST_ZRES_BIT 2
`define ASU_ST_FAULT_BIT 3
`define ASU_ST_BUSY_BIT 4
`define ASU_ST_DEPTH_LSB 8

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define ASU_CTRL_EN_RST 1'h1
`define ASU_STACK_DEPTH 8
`define ASU_DEPTH_W 4
`define ASU_MEM_TOP 16'h3fff
`define ASU_FMT_MAX 6'h20

`endif

// File: inc/asu_pkg.sv
// Types shared by the accumulator/stack store unit and its surroundings
package asu_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    nop_op = 4'h0,
    word_load_op = 4'h1,
    address_load_op = 4'h2,
    real_load_op = 4'h3,
    word_store_op = 4'h4,
    double_store_op = 4'h5,
    formatted_store_op = 4'h6,
    pop_op = 4'h7,
    indexed_store_op = 4'h8,
    low_byte_store_op = 4'h9,
    high_byte_store_op = 4'ha,
    and_word_op = 4'hb
  } asu_op_type;

  typedef enum logic [3:0] {
    st_idle = 4'h0,
    st_ptr = 4'h1,
    st_exec = 4'h2,
    st_rd0 = 4'h3,
    st_rd1 = 4'h4,
    st_wr0 = 4'h5,
    st_wr1 = 4'h6,
    st_bits = 4'h7,
    st_done = 4'h8
  } asu_state_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    asu_op_type op;
    logic indirect;
    logic use_const;
    logic [15:0] addr;
    logic [31:0] konst;
    logic [5:0] nbits;
  } asu_cmd_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } asu_mem_req_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic data;
  } asu_bit_wr_type;

  typedef struct packed {
    logic solve_fault_flag;
    logic zero_result_flag;
    logic load_zero_flag;
    logic sign_flag;
  } asu_flags_type;

endpackage : asu_pkg

// File: logic/asu_unit.sv
// Accumulator, stack and store unit of the controller CPU, with a Wishbone register slave
// Function
// - Real load fills accumulator from memory/constant
// - Real values are two adjacent 16-bit words
// - Real load sets sign flag when negative
// - Real load sets load-zero flag on zero
// - Word store writes accumulator low word
// - Word/double/indexed stores raise solve-fault flag
// - Double store writes low word first, lower address
// - Formatted store copies 1-32 low bits
// - Pop moves stack top, shifts stack up
// - Pop sets zero-result flag on zero
// - Indexed store writes stack top at base+offset
// - Index offset is plain binary word count
// - Indexed store clears accumulator upper half
// - Back-to-back loads push first value
// - Low-byte store copies bits 7..0
// - High-byte store copies bits 15..8
// - AND combines low word with memory word
// - AND sets zero-result flag on zero
// - Flags hold until same flag rewritten
// - Word load clears accumulator upper half
`timescale 1ns/1ps
`include "asu_cfg.svh"

module asu_unit
  import asu_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmd_valid,
  input wire asu_cmd_type cmd,
  output logic cmd_ready,
  output logic done,
  output asu_mem_req_type mem_o,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output asu_bit_wr_type bit_o,
  output asu_flags_type flags_o,
  output logic [31:0] acc_o
);

  localparam int DEPTH = `ASU_STACK_DEPTH;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [15:0] a);
    addr_ok = (a <= `ASU_MEM_TOP);
  endfunction : addr_ok
  function automatic logic is_load(input asu_op_type op);
    is_load = (op == word_load_op) || (op == address_load_op) || (op == real_load_op);
  endfunction : is_load
  // Count of 0 is read as 1 and anything past 32 as 32
  function automatic logic [5:0] fmt_count(input logic [5:0] n);
    fmt_count = (n == 6'h00) ? 6'h01 : ((n > `ASU_FMT_MAX) ? `ASU_FMT_MAX : n);
  endfunction : fmt_count
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  asu_state_type state_r;
  asu_cmd_type cur_r;
  logic [15:0] ea_r, rd_lo_r, rd_hi_r, idx_addr, ea_next;
  logic fault_r, cmd_ready_r, done_r, last_load_r, ctrl_en_r, wb_ack_r, commit, push_now, pop_now;
  logic [5:0] bit_idx_r;
  asu_mem_req_type mem_r;
  asu_bit_wr_type bit_r;
  logic [31:0] acc_r, wb_dat_r, load_val;
  logic [31:0] stack_r [DEPTH];
  logic [`ASU_DEPTH_W-1:0] depth_r;
  asu_flags_type flags_r;
  assign wb_dat_o = wb_dat_r;
  assign wb_ack_o = wb_ack_r;
  assign cmd_ready = cmd_ready_r;
  assign done = done_r;
  assign mem_o = mem_r;
  assign bit_o = bit_r;
  assign flags_o = flags_r;
  assign acc_o = acc_r;
  assign commit = (state_r == st_done);
  assign ea_next = ea_r + 16'h0001;
  assign idx_addr = ea_r + acc_r[15:0];

  // ----------------------------------------------------------------
  // Sequencer and data memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= st_idle;
      cur_r <= '0;
      ea_r <= 16'h0000;
      rd_lo_r <= 16'h0000;
      rd_hi_r <= 16'h0000;
      fault_r <= 1'b0;
      bit_idx_r <= 6'h00;
      mem_r <= '0;
      bit_r <= '0;
      cmd_ready_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        st_idle: begin
          if (cmd_valid && cmd_ready_r) begin
            cur_r <= cmd;
            cmd_ready_r <= 1'b0;
            fault_r <= 1'b0;
            if (cmd.indirect && !cmd.use_const) begin
              mem_r <= '{req: 1'b1, we: 1'b0, addr: cmd.addr, wdata: 16'h0000};
              state_r <= st_ptr;
            end else begin
              ea_r <= cmd.addr;
              state_r <= st_exec;
            end
          end else begin
            cmd_ready_r <= ctrl_en_r;
          end
        end
        st_ptr: begin
          // The pointer holds a plain word address
          if (mem_ack) begin
            mem_r.req <= 1'b0;
            ea_r <= mem_rdata;
            state_r <= st_exec;
          end
        end
        st_exec: begin
          state_r <= st_done;
          unique case (cur_r.op)
            word_load_op, real_load_op, and_word_op: begin
              if (!cur_r.use_const || cur_r.op == and_word_op) begin
                if (!addr_ok(ea_r) || (cur_r.op == real_load_op && !addr_ok(ea_next))) begin
                  fault_r <= 1'b1;
                end else begin
                  mem_r <= '{req: 1'b1, we: 1'b0, addr: ea_r, wdata: 16'h0000};
                  state_r <= st_rd0;
                end
              end
            end
            word_store_op: begin
              if (!addr_ok(ea_r)) begin
                fault_r <= 1'b1;
              end else begin
                mem_r <= '{req: 1'b1, we: 1'b1, addr: ea_r, wdata: acc_r[15:0]};
                state_r <= st_wr1;
              end
            end
            double_store_op: begin
              if (!addr_ok(ea_r) || !addr_ok(ea_next)) begin
                fault_r <= 1'b1;
              end else begin
                mem_r <= '{req: 1'b1, we: 1'b1, addr: ea_r, wdata: acc_r[15:0]};
                state_r <= st_wr0;
              end
            end
            low_byte_store_op, high_byte_store_op: begin
              if (!addr_ok(ea_r)) begin
                fault_r <= 1'b1;
              end else begin
                // Read first so the untouched byte survives
                mem_r <= '{req: 1'b1, we: 1'b0, addr: ea_r, wdata: 16'h0000};
                state_r <= st_rd0;
              end
            end
            indexed_store_op: begin
              if (!addr_ok(idx_addr)) begin
                fault_r <= 1'b1;
              end else begin
                mem_r <= '{req: 1'b1, we: 1'b1, addr: idx_addr, wdata: stack_r[0][15:0]};
                state_r <= st_wr1;
              end
            end
            formatted_store_op: begin
              bit_idx_r <= 6'h00;
              state_r <= st_bits;
            end
            default: state_r <= st_done;
          endcase
        end
        st_rd0: begin
          if (mem_ack) begin
            rd_lo_r <= mem_rdata;
            mem_r.req <= 1'b0;
            state_r <= st_done;
            if (cur_r.op == real_load_op) begin
              mem_r <= '{req: 1'b1, we: 1'b0, addr: ea_next, wdata: 16'h0000};
              state_r <= st_rd1;
            end else if (cur_r.op == low_byte_store_op) begin
              mem_r <= '{req: 1'b1, we: 1'b1, addr: ea_r, wdata: {mem_rdata[15:8], acc_r[7:0]}};
              state_r <= st_wr1;
            end else if (cur_r.op == high_byte_store_op) begin
              mem_r <= '{req: 1'b1, we: 1'b1, addr: ea_r, wdata: {acc_r[15:8], mem_rdata[7:0]}};
              state_r <= st_wr1;
            end
          end
        end
        st_rd1: begin
          if (mem_ack) begin
            rd_hi_r <= mem_rdata;
            mem_r.req <= 1'b0;
            state_r <= st_done;
          end
        end
        st_wr0: begin
          if (mem_ack) begin
            mem_r <= '{req: 1'b1, we: 1'b1, addr: ea_next, wdata: acc_r[31:16]};
            state_r <= st_wr1;
          end
        end
        st_wr1: begin
          if (mem_ack) begin
            mem_r <= '0;
            state_r <= st_done;
          end
        end
        st_bits: begin
          // One discrete bit per cycle, lowest bit to the start address
          bit_r.we <= 1'b1;
          bit_r.addr <= ea_r + {10'h000, bit_idx_r};
          bit_r.data <= acc_r[bit_idx_r[4:0]];
          bit_idx_r <= bit_idx_r + 6'h01;
          state_r <= (bit_idx_r == fmt_count(cur_r.nbits) - 6'h01) ? st_done : st_bits;
        end
        st_done: begin
          bit_r.we <= 1'b0;
          done_r <= 1'b1;
          cmd_ready_r <= ctrl_en_r;
          state_r <= st_idle;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cur_r.op)
      real_load_op: load_val = cur_r.use_const ? cur_r.konst : {rd_hi_r, rd_lo_r};
      address_load_op: load_val = {16'h0000, cur_r.konst[15:0]};
      default: load_val = {16'h0000, (cur_r.use_const ? cur_r.konst[15:0] : rd_lo_r)};
    endcase
  end
  // A load after a load saves the earlier value on the stack first
  assign push_now = commit && is_load(cur_r.op) && !fault_r && last_load_r;
  assign pop_now = commit && (cur_r.op == pop_op) && (depth_r != '0);
  // Flags change only on instructions that own them; otherwise they hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= 32'h0000_0000;
      flags_r <= '0;
      last_load_r <= 1'b0;
    end else if (commit) begin
      last_load_r <= is_load(cur_r.op) && !fault_r;
      if (cur_r.indirect || cur_r.op == word_store_op || cur_r.op == double_store_op ||
          cur_r.op == indexed_store_op) begin
        flags_r.solve_fault_flag <= fault_r;
      end
      unique case (cur_r.op)
        word_load_op, address_load_op, real_load_op: begin
          if (!fault_r) begin
            acc_r <= load_val;
            flags_r.sign_flag <= load_val[31];
            flags_r.load_zero_flag <= (load_val == 32'h0000_0000);
          end
        end
        pop_op: begin
          acc_r <= (depth_r != '0) ? stack_r[0] : 32'h0000_0000;
          flags_r.zero_result_flag <= (depth_r == '0) || (stack_r[0] == 32'h0000_0000);
        end
        and_word_op: begin
          if (!fault_r) begin
            acc_r <= {16'h0000, acc_r[15:0] & rd_lo_r};
            flags_r.zero_result_flag <= ((acc_r[15:0] & rd_lo_r) == 16'h0000);
          end
        end
        indexed_store_op: begin
          if (!fault_r) begin
            acc_r[31:16] <= 16'h0000;
          end
        end
        default: acc_r <= acc_r;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Stack: entry 0 is the top; a push onto a full stack loses the bottom
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      depth_r <= '0;
    end else if (push_now && depth_r != DEPTH[`ASU_DEPTH_W-1:0]) begin
      depth_r <= depth_r + 1'b1;
    end else if (pop_now) begin
      depth_r <= depth_r - 1'b1;
    end
  end
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_stack
      logic [31:0] push_src;
      logic [31:0] pop_src;
      if (i == 0) begin : g_top
        assign push_src = acc_r;
      end else begin : g_mid
        assign push_src = stack_r[i-1];
      end
      if (i == DEPTH - 1) begin : g_bot
        assign pop_src = 32'h0000_0000;
      end else begin : g_up
        assign pop_src = stack_r[i+1];
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stack_r[i] <= 32'h0000_0000;
        end else if (push_now) begin
          stack_r[i] <= push_src;
        end else if (pop_now) begin
          stack_r[i] <= pop_src;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // Wishbone slave: one-cycle answer, unmapped reads give zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      ctrl_en_r <= `ASU_CTRL_EN_RST;
    end else begin
      wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
      if (wb_cyc_i && wb_stb_i && !wb_ack_r) begin
        if (wb_we_i && {wb_adr_i[7:2], 2'b00} == `ASU_ADR_CTRL && wb_sel_i[0]) begin
          ctrl_en_r <= wb_dat_i[`ASU_CTRL_EN_BIT];
        end else if (!wb_we_i) begin
          wb_dat_r <= 32'h0000_0000;
          unique case ({wb_adr_i[7:2], 2'b00})
            `ASU_ADR_CTRL: wb_dat_r[`ASU_CTRL_EN_BIT] <= ctrl_en_r;
            `ASU_ADR_STAT: begin
              wb_dat_r[`ASU_ST_SIGN_BIT] <= flags_r.sign_flag;
              wb_dat_r[`ASU_ST_LZERO_BIT] <= flags_r.load_zero_flag;
              wb_dat_r[`ASU_ST_ZRES_BIT] <= flags_r.zero_result_flag;
              wb_dat_r[`ASU_ST_FAULT_BIT] <= flags_r.solve_fault_flag;
              wb_dat_r[`ASU_ST_BUSY_BIT] <= (state_r != st_idle);
              wb_dat_r[`ASU_ST_DEPTH_LSB +: `ASU_DEPTH_W] <= depth_r;
            end
            `ASU_ADR_ACC: wb_dat_r <= acc_r;
            `ASU_ADR_TOS: wb_dat_r <= (depth_r != '0) ? stack_r[0] : 32'h0000_0000;
            default: wb_dat_r <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

endmodule : asu_unit

// File: verification/asu_unit_monitor.sv
// Port-level assertions of the accumulator/stack store unit
`timescale 1ns/1ps
module asu_unit_monitor
  import asu_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cmd_valid,
  input wire asu_cmd_type cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire asu_mem_req_type mem_o,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire asu_bit_wr_type bit_o,
  input wire asu_flags_type flags_o,
  input wire logic [31:0] acc_o
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  asu_op_type op_r;
  logic [15:0] start_r;
  logic [15:0] idx;
  assign idx = bit_o.addr - start_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_r <= nop_op;
      start_r <= 16'h0000;
    end else if (cmd_valid && cmd_ready) begin
      op_r <= cmd.op;
      start_r <= cmd.addr;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_accept;
    cmd_valid && cmd_ready;
  endsequence
  // Instructions that end with the solve-fault flag set are skipped, so their results are not judged
  sequence s_fin(asu_op_type o);
    done && op_r == o && !flags_o.solve_fault_flag;
  endsequence
  a_ack_once: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");
  a_cmd_done: assert property (s_accept |=> !cmd_ready ##[0:300] done)
    else $error("instruction never finished");
  a_req_hold: assert property (mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.wdata))
    else $error("memory request dropped early");
  a_result_at_done: assert property (($changed(acc_o) || $changed(flags_o)) |-> done)
    else $error("result moved outside done");
  a_word_data: assert property (mem_o.req && mem_o.we && op_r == word_store_op |-> mem_o.wdata == acc_o[15:0])
    else $error("word store data wrong");
  a_low_byte: assert property (mem_o.req && mem_o.we && op_r == low_byte_store_op
    |-> mem_o.wdata[7:0] == acc_o[7:0])
    else $error("low byte store data wrong");
  a_high_byte: assert property (mem_o.req && mem_o.we && op_r == high_byte_store_op
    |-> mem_o.wdata[15:8] == acc_o[15:8])
    else $error("high byte store data wrong");
  a_bit_copy: assert property (bit_o.we |-> bit_o.data == acc_o[idx[4:0]])
    else $error("formatted bit wrong");
  a_real_flags: assert property (s_fin(real_load_op)
    |-> flags_o.sign_flag == acc_o[31] && flags_o.load_zero_flag == (acc_o == 32'h0))
    else $error("real load flags wrong");
  a_zero_flag: assert property (done && (op_r == pop_op || op_r == and_word_op && !flags_o.solve_fault_flag)
    |-> flags_o.zero_result_flag == (acc_o == 32'h0))
    else $error("zero result flag wrong");
  a_index_upper: assert property (s_fin(indexed_store_op) |-> acc_o[31:16] == 16'h0)
    else $error("indexed store kept upper half");
endmodule : asu_unit_monitor

// File: verification/asu_mem_model.sv
// Behavioural data store and bit memory on the far side of the unit
`timescale 1ns/1ps
module asu_mem_model
  import asu_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire asu_mem_req_type mem_o,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  input wire asu_bit_wr_type bit_o
);
  logic [15:0] words [0:16383];
  logic bits [0:255];
  logic [3:0] wait_r;
  // Read data is good only with the ack; it toggles otherwise so a late sample shows
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_r <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (bit_o.we) begin
        bits[bit_o.addr[7:0]] <= bit_o.data;
      end
      if (mem_o.req && !mem_ack && wait_r != lat) begin
        wait_r <= wait_r + 4'h1;
      end else if (mem_o.req && !mem_ack) begin
        wait_r <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_o.we) begin
          words[mem_o.addr[13:0]] <= mem_o.wdata;
        end else begin
          mem_rdata <= words[mem_o.addr[13:0]];
        end
      end
    end
  end
endmodule : asu_mem_model

// File: verification/testbench.sv
// Self-checking testbench of the accumulator/stack store unit
`timescale 1ns/1ps
module testbench import asu_pkg::*;;
  logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_valid, cmd_ready, done, mem_ack;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, lat;
  logic [31:0] wb_dat_i, wb_dat_o, acc_o, q;
  logic [15:0] mem_rdata;
  asu_cmd_type cmd;
  asu_mem_req_type mem_o;
  asu_bit_wr_type bit_o;
  asu_flags_type flags_o;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  asu_unit dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .bit_o(bit_o), .flags_o(flags_o), .acc_o(acc_o));
  asu_mem_model m (.clk(clk), .rstn(rstn), .lat(lat), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .bit_o(bit_o));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // Format count fixed at 32, the widest case
  task run(input asu_op_type op, input logic ind, input logic uc, input logic [15:0] a, input logic [31:0] k);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, ind, uc, a, k, 6'h20};
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
  endtask : run
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run needs a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, cmd_valid, wb_adr_i, wb_dat_i, lat} = '0;
    wb_sel_i = 4'hf;
    cmd = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 8'h00, 32'h0);
    check(q, 32'h1);
    wb(1'b1, 8'h00, 32'h0);
    @(posedge clk);
    check({31'h0, cmd_ready}, 32'h0);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
    run(real_load_op, 1'b0, 1'b1, 16'h0, 32'hc0490fdb);
    check(acc_o, 32'hc0490fdb);
    check({31'h0, flags_o.sign_flag}, 32'h1);
    run(word_load_op, 1'b0, 1'b1, 16'h0, 32'hffff5a5a);
    check(acc_o, 32'h00005a5a);
    wb(1'b0, 8'h0c, 32'h0);
    check(q, 32'hc0490fdb);
    run(word_store_op, 1'b0, 1'b0, 16'h0100, 32'h0);
    check({16'h0, m.words[14'h100]}, 32'h5a5a);
    m.words[14'h200] = 16'h5678;
    m.words[14'h201] = 16'h1234;
    m.words[14'h202] = 16'h0000;
    m.words[14'h203] = 16'h0000;
    lat <= 4'h2;
    run(real_load_op, 1'b0, 1'b0, 16'h0200, 32'h0);
    check(acc_o, 32'h12345678);
    run(double_store_op, 1'b0, 1'b0, 16'h0300, 32'h0);
    check({m.words[14'h301], m.words[14'h300]}, 32'h12345678);
    run(real_load_op, 1'b0, 1'b0, 16'h0202, 32'h0);
    check({31'h0, flags_o.load_zero_flag}, 32'h1);
    run(pop_op, 1'b0, 1'b0, 16'h0, 32'h0);
    check(acc_o, 32'hc0490fdb);
    check({31'h0, flags_o.zero_result_flag}, 32'h0);
    run(pop_op, 1'b0, 1'b0, 16'h0, 32'h0);
    check(acc_o, 32'h0);
    check({31'h0, flags_o.zero_result_flag}, 32'h1);
    check({31'h0, flags_o.load_zero_flag}, 32'h1);
    run(word_load_op, 1'b0, 1'b1, 16'h0, 32'h3544);
    run(real_load_op, 1'b0, 1'b1, 16'h0, 32'habcd0015);
    run(indexed_store_op, 1'b0, 1'b0, 16'h1400, 32'h0);
    check({16'h0, m.words[14'h1415]}, 32'h3544);
    check(acc_o, 32'h15);
    m.words[14'h050] = 16'hffff;
    run(word_store_op, 1'b1, 1'b0, 16'h0050, 32'h0);
    check({31'h0, flags_o.solve_fault_flag}, 32'h1);
    run(word_store_op, 1'b0, 1'b0, 16'h0104, 32'h0);
    check({31'h0, flags_o.solve_fault_flag}, 32'h0);
    m.words[14'h400] = 16'haaaa;
    m.words[14'h401] = 16'h5555;
    lat <= 4'h3;
    run(word_load_op, 1'b0, 1'b1, 16'h0, 32'h1234);
    run(low_byte_store_op, 1'b0, 1'b0, 16'h0400, 32'h0);
    check({16'h0, m.words[14'h400]}, 32'haa34);
    run(high_byte_store_op, 1'b0, 1'b0, 16'h0401, 32'h0);
    check({16'h0, m.words[14'h401]}, 32'h1255);
    m.words[14'h500] = 16'h0f0f;
    m.words[14'h051] = 16'h0501;
    m.words[14'h501] = 16'hf0f0;
    lat <= 4'h0;
    run(and_word_op, 1'b0, 1'b0, 16'h0500, 32'h0);
    check(acc_o, 32'h0204);
    run(and_word_op, 1'b1, 1'b0, 16'h0051, 32'h0);
    check({31'h0, flags_o.zero_result_flag}, 32'h1);
    run(real_load_op, 1'b0, 1'b1, 16'h0, 32'h80000005);
    run(formatted_store_op, 1'b0, 1'b0, 16'h0020, 32'h0);
    for (int i = 0; i < 32; i++) begin
      check({31'h0, m.bits[32 + i]}, {31'h0, i == 0 || i == 2 || i == 31});
    end
    run(address_load_op, 1'b0, 1'b1, 16'h0, 32'hffff8001);
    run(word_load_op, 1'b0, 1'b1, 16'h0, 32'h0);
    wb(1'b0, 8'h0c, 32'h0);
    check(q, 32'h00008001);
    test_done();
  end
endmodule : testbench

bind asu_unit asu_unit_monitor u_mon (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .mem_o(mem_o),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bit_o(bit_o), .flags_o(flags_o), .acc_o(acc_o));
